// [rtl/pll_div_pkg.sv]
// constants, types and value checks for the divider configuration block
// How it works
// - Each output runs at input rate times feedback ratio over output ratio times input ratio.
// - Each output ratio is the shared fast output stage times that output's slow stage.
// - The shared fast output stage takes only the whole values 4 to 11.
// - A per-output slow stage takes 1 or any even value from 2 to 2^20.
// - On narrowband parts the feedback ratio is a fast stage (4 to 11) times an even slow stage 2 to 2^20.
// - On wideband parts the feedback slow stage takes only even values 32 to 2^9.
// - Every input has its own input stage taking any whole value 1 to 2^19.
// - One fast output stage feeds every output, so all outputs divide the one oscillator.
// - A 4-bit field picks loop bandwidth, set after the frequency plan is fixed.
// - On standard narrowband parts the bandwidth range spans 60 Hz to 8.4 kHz.
// - On low-bandwidth parts each setting gives about one sixteenth of the standard value.
// - Wideband parts offer no loss-of-lock flag and no input-to-output skew control.
package pll_div_pkg;

  localparam int unsigned FAST_W = 4;
  localparam int unsigned SLOW_W = 21;
  localparam int unsigned IN_W   = 20;
  localparam int unsigned BW_W   = 4;
  localparam int unsigned ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFS_FAST_OUT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SLOW_OUT0 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SLOW_OUT1 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FB_FAST  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_FB_SLOW  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IN_DIV0  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IN_DIV1  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_LOOP_BW  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CONTROL  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h24;

  localparam int unsigned ST_REJECT   = 0;
  localparam int unsigned ST_WIDEBAND = 1;
  localparam int unsigned ST_LOW_BW   = 2;
  localparam int unsigned ST_LOCK_IND = 3;
  localparam int unsigned CTL_IN_SEL  = 0;

  localparam logic [FAST_W-1:0] FAST_MIN = 4'h4;
  localparam logic [FAST_W-1:0] FAST_MAX = 4'hB;
  localparam logic [SLOW_W-1:0] SLOW_MAX = 21'h100000;
  localparam logic [SLOW_W-1:0] WB_FB_MIN = 21'h000020;
  localparam logic [SLOW_W-1:0] WB_FB_MAX = 21'h000200;
  localparam logic [IN_W-1:0]   IN_MAX   = 20'h80000;

  localparam logic [FAST_W-1:0] RST_FAST    = 4'h4;
  localparam logic [SLOW_W-1:0] RST_SLOW    = 21'h000001;
  localparam logic [SLOW_W-1:0] RST_FB_SLOW = 21'h000020;
  localparam logic [IN_W-1:0]   RST_IN_DIV  = 20'h00001;
  localparam logic [BW_W-1:0]   RST_LOOP_BW = 4'h0;
  localparam logic [1:0]        STRAP_DELAY = 2'h3;

  typedef struct packed {
    logic [FAST_W-1:0] fast_out;
    logic [SLOW_W-1:0] slow_out0;
    logic [SLOW_W-1:0] slow_out1;
    logic [FAST_W-1:0] fb_fast;
    logic [SLOW_W-1:0] fb_slow;
    logic [IN_W-1:0]   in_div0;
    logic [IN_W-1:0]   in_div1;
  } div_cfg_t;

  function automatic logic fast_ok(input logic [FAST_W-1:0] v);
    fast_ok = (v >= FAST_MIN) && (v <= FAST_MAX);
  endfunction : fast_ok

  function automatic logic even_in(input logic [SLOW_W-1:0] v,
                                   input logic [SLOW_W-1:0] lo,
                                   input logic [SLOW_W-1:0] hi);
    even_in = !v[0] && (v >= lo) && (v <= hi);
  endfunction : even_in

  function automatic logic in_ok(input logic [IN_W-1:0] v);
    in_ok = (v != 20'h00000) && (v <= IN_MAX);
  endfunction : in_ok

endpackage : pll_div_pkg

// [rtl/div_counter.sv]
// reloading ratio counter: pulse and square level per configured count
`timescale 1ns/1ps
module div_counter (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  input  wire logic        restart_i,
  input  wire logic [20:0] ratio_i,
  output logic             pulse_o,
  output logic             level_o
);

  logic [20:0] count;
  logic [20:0] next_count;
  logic        at_last;
  logic        ratio_one;

  assign ratio_one  = (ratio_i == 21'h000001);
  assign at_last    = (count >= 21'(ratio_i - 21'h000001));
  assign next_count = at_last ? 21'h000000 : 21'(count + 21'h000001);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count   <= 21'h000000;
      pulse_o <= 1'b0;
      level_o <= 1'b0;
    end else if (restart_i) begin
      count   <= 21'h000000;
      pulse_o <= 1'b0;
      level_o <= 1'b0;
    end else begin
      // one pulse per ratio enables, counter reloads from zero
      pulse_o <= en_i && at_last;
      if (en_i) begin
        count   <= next_count;
        level_o <= ratio_one ? 1'b1 : (next_count < (ratio_i >> 1));
      end else if (ratio_one) begin
        level_o <= 1'b0;
      end
    end
  end

endmodule : div_counter

// [rtl/pll_divider_config.sv]
// divider chain, value checks and register port of the clock multiplier
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module pll_divider_config (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        osc_tick_i,
  input  wire logic        clk_in0_i,
  input  wire logic        clk_in1_i,
  input  wire logic        strap_wideband_i,
  input  wire logic        strap_low_bw_i,
  output logic      [1:0]  clk_out_o,
  output logic      [1:0]  out_pulse_o,
  output logic             feedback_pulse_o,
  output logic             pd_ref_pulse_o,
  output logic      [3:0]  loop_bw_select_o,
  output logic             low_bw_scale_o,
  output logic             lock_ind_avail_o
);

  pll_div_pkg::div_cfg_t cfg;
  logic [3:0]  loop_bw_select;
  logic        in_sel;
  logic        reject_flag;
  logic        wideband;
  logic        low_bw;
  logic [1:0]  strap_wait;
  logic        strap_taken;
  logic [1:0]  wb_sync;
  logic [1:0]  lb_sync;
  logic [2:0]  in0_sync;
  logic [2:0]  in1_sync;

  // decode of the register port
  wire hit_fast_out  = (addr_i == pll_div_pkg::OFS_FAST_OUT);
  wire hit_slow_out0 = (addr_i == pll_div_pkg::OFS_SLOW_OUT0);
  wire hit_slow_out1 = (addr_i == pll_div_pkg::OFS_SLOW_OUT1);
  wire hit_fb_fast   = (addr_i == pll_div_pkg::OFS_FB_FAST);
  wire hit_fb_slow   = (addr_i == pll_div_pkg::OFS_FB_SLOW);
  wire hit_in_div0   = (addr_i == pll_div_pkg::OFS_IN_DIV0);
  wire hit_in_div1   = (addr_i == pll_div_pkg::OFS_IN_DIV1);
  wire hit_loop_bw   = (addr_i == pll_div_pkg::OFS_LOOP_BW);
  wire hit_control   = (addr_i == pll_div_pkg::OFS_CONTROL);
  wire hit_status    = (addr_i == pll_div_pkg::OFS_STATUS);

  wire [3:0]  wr_fast = wdata_i[3:0];
  wire [20:0] wr_slow = wdata_i[20:0];
  wire [19:0] wr_in   = wdata_i[19:0];
  wire        wr_hi_fast = (wdata_i[31:4] != 28'h0000000);
  wire        wr_hi_slow = (wdata_i[31:21] != 11'h000);
  wire        wr_hi_in   = (wdata_i[31:20] != 12'h000);

  // legality of each written value; illegal values are refused
  wire ok_fast_out = !wr_hi_fast && pll_div_pkg::fast_ok(wr_fast);
  wire ok_slow_out = !wr_hi_slow && ((wr_slow == 21'h000001) ||
                     pll_div_pkg::even_in(wr_slow, 21'h000002,
                                          pll_div_pkg::SLOW_MAX));
  wire ok_fb_fast  = !wr_hi_fast && pll_div_pkg::fast_ok(wr_fast);
  wire ok_fb_narrow = pll_div_pkg::even_in(wr_slow, 21'h000002,
                                           pll_div_pkg::SLOW_MAX);
  wire ok_fb_wide  = pll_div_pkg::even_in(wr_slow,
                                          pll_div_pkg::WB_FB_MIN,
                                          pll_div_pkg::WB_FB_MAX);
  wire ok_fb_slow  = !wr_hi_slow && (wideband ? ok_fb_wide : ok_fb_narrow);
  wire ok_in_div   = !wr_hi_in && pll_div_pkg::in_ok(wr_in);
  wire ok_loop_bw  = (wdata_i[31:4] == 28'h0000000);

  wire we_fast_out  = wr_i && hit_fast_out  && ok_fast_out;
  wire we_slow_out0 = wr_i && hit_slow_out0 && ok_slow_out;
  wire we_slow_out1 = wr_i && hit_slow_out1 && ok_slow_out;
  wire we_fb_fast   = wr_i && hit_fb_fast   && ok_fb_fast;
  wire we_fb_slow   = wr_i && hit_fb_slow   && ok_fb_slow;
  wire we_in_div0   = wr_i && hit_in_div0   && ok_in_div;
  wire we_in_div1   = wr_i && hit_in_div1   && ok_in_div;
  wire we_loop_bw   = wr_i && hit_loop_bw   && ok_loop_bw;

  wire bad_write = wr_i && ((hit_fast_out && !ok_fast_out) ||
                   ((hit_slow_out0 || hit_slow_out1) && !ok_slow_out) ||
                   (hit_fb_fast && !ok_fb_fast) ||
                   (hit_fb_slow && !ok_fb_slow) ||
                   ((hit_in_div0 || hit_in_div1) && !ok_in_div) ||
                   (hit_loop_bw && !ok_loop_bw));
  wire clr_reject = wr_i && hit_status && wdata_i[pll_div_pkg::ST_REJECT];

  // straps settle through the synchroniser before being captured once
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_sync     <= 2'h0;
      lb_sync     <= 2'h0;
      strap_wait  <= 2'h0;
      strap_taken <= 1'b0;
      wideband    <= 1'b0;
      low_bw      <= 1'b0;
    end else begin
      wb_sync <= {wb_sync[0], strap_wideband_i};
      lb_sync <= {lb_sync[0], strap_low_bw_i};
      if (!strap_taken) begin
        strap_wait <= 2'(strap_wait + 2'h1);
        if (strap_wait == pll_div_pkg::STRAP_DELAY) begin
          strap_taken <= 1'b1;
          wideband    <= wb_sync[1];
          low_bw      <= lb_sync[1];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg.fast_out   <= pll_div_pkg::RST_FAST;
      cfg.slow_out0  <= pll_div_pkg::RST_SLOW;
      cfg.slow_out1  <= pll_div_pkg::RST_SLOW;
      cfg.fb_fast    <= pll_div_pkg::RST_FAST;
      cfg.fb_slow    <= pll_div_pkg::RST_FB_SLOW;
      cfg.in_div0    <= pll_div_pkg::RST_IN_DIV;
      cfg.in_div1    <= pll_div_pkg::RST_IN_DIV;
      loop_bw_select <= pll_div_pkg::RST_LOOP_BW;
      in_sel         <= 1'b0;
    end else begin
      if (we_fast_out)  cfg.fast_out  <= wr_fast;
      if (we_slow_out0) cfg.slow_out0 <= wr_slow;
      if (we_slow_out1) cfg.slow_out1 <= wr_slow;
      if (we_fb_fast)   cfg.fb_fast   <= wr_fast;
      if (we_fb_slow)   cfg.fb_slow   <= wr_slow;
      if (we_in_div0)   cfg.in_div0   <= wr_in;
      if (we_in_div1)   cfg.in_div1   <= wr_in;
      if (we_loop_bw)   loop_bw_select <= wdata_i[3:0];
      if (wr_i && hit_control) in_sel <= wdata_i[pll_div_pkg::CTL_IN_SEL];
    end
  end

  // a refused write in the same cycle as the clear keeps the flag set
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reject_flag <= 1'b0;
    end else begin
      reject_flag <= bad_write || (reject_flag && !clr_reject);
    end
  end

  wire [31:0] status_word = {28'h0000000, !wideband, low_bw, wideband,
                             reject_flag};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (1'b1)
      hit_fast_out:  rd_mux = {28'h0000000, cfg.fast_out};
      hit_slow_out0: rd_mux = {11'h000, cfg.slow_out0};
      hit_slow_out1: rd_mux = {11'h000, cfg.slow_out1};
      hit_fb_fast:   rd_mux = {28'h0000000, cfg.fb_fast};
      hit_fb_slow:   rd_mux = {11'h000, cfg.fb_slow};
      hit_in_div0:   rd_mux = {12'h000, cfg.in_div0};
      hit_in_div1:   rd_mux = {12'h000, cfg.in_div1};
      hit_loop_bw:   rd_mux = {28'h0000000, loop_bw_select};
      hit_control:   rd_mux = {31'h00000000, in_sel};
      hit_status:    rd_mux = status_word;
      default:       rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= rd_i ? rd_mux : 32'h00000000;
    end
  end

  // input clocks are asynchronous: two flops, then edge detect on later ones
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in0_sync <= 3'h0;
      in1_sync <= 3'h0;
    end else begin
      in0_sync <= {in0_sync[1:0], clk_in0_i};
      in1_sync <= {in1_sync[1:0], clk_in1_i};
    end
  end
  wire in0_rise = in0_sync[1] && !in0_sync[2];
  wire in1_rise = in1_sync[1] && !in1_sync[2];

  logic fast_out_pulse;
  logic fb_fast_pulse;
  logic pd0_pulse;
  logic pd1_pulse;

  // one shared fast stage clocked by the oscillator feeds both outputs
  div_counter u_fast_out (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .en_i       (osc_tick_i),
    .restart_i  (we_fast_out),
    .ratio_i    ({17'h00000, cfg.fast_out}),
    .pulse_o    (fast_out_pulse),
    .level_o    ()
  );

  // output ratio is the shared fast stage times the slow stage
  div_counter u_slow_out0 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .en_i       (fast_out_pulse),
    .restart_i  (we_slow_out0 || we_fast_out),
    .ratio_i    (cfg.slow_out0),
    .pulse_o    (out_pulse_o[0]),
    .level_o    (clk_out_o[0])
  );

  div_counter u_slow_out1 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .en_i       (fast_out_pulse),
    .restart_i  (we_slow_out1 || we_fast_out),
    .ratio_i    (cfg.slow_out1),
    .pulse_o    (out_pulse_o[1]),
    .level_o    (clk_out_o[1])
  );

  // feedback ratio is fast times slow stage, compared at the detector
  div_counter u_fb_fast (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .en_i       (osc_tick_i),
    .restart_i  (we_fb_fast),
    .ratio_i    ({17'h00000, cfg.fb_fast}),
    .pulse_o    (fb_fast_pulse),
    .level_o    ()
  );

  div_counter u_fb_slow (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .en_i       (fb_fast_pulse),
    .restart_i  (we_fb_slow || we_fb_fast),
    .ratio_i    (cfg.fb_slow),
    .pulse_o    (feedback_pulse_o),
    .level_o    ()
  );

  // each input has its own stage; both run so a switch needs no restart
  div_counter u_in_div0 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .en_i       (in0_rise),
    .restart_i  (we_in_div0),
    .ratio_i    ({1'b0, cfg.in_div0}),
    .pulse_o    (pd0_pulse),
    .level_o    ()
  );

  div_counter u_in_div1 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .en_i       (in1_rise),
    .restart_i  (we_in_div1),
    .ratio_i    ({1'b0, cfg.in_div1}),
    .pulse_o    (pd1_pulse),
    .level_o    ()
  );

  // the detector sees one rate only; matching the stages is up to software
  assign pd_ref_pulse_o   = in_sel ? pd1_pulse : pd0_pulse;
  assign loop_bw_select_o = loop_bw_select;
  assign low_bw_scale_o   = low_bw;
  assign lock_ind_avail_o = !wideband;

endmodule : pll_divider_config

// [verification/pll_divider_config_checker.sv]
// port assertions for the divider configuration block
`timescale 1ns/1ps
module pll_divider_config_checker (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [31:0] rdata_o,
  input  wire logic [1:0]  out_pulse_o,
  input  wire logic        feedback_pulse_o,
  input  wire logic [3:0]  loop_bw_select_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire bw_wr = wr_i && (addr_i == 8'h1C);
  a_bw_takes_write: assert property (
    bw_wr && wdata_i[31:4] == 28'h0 |=>
      loop_bw_select_o == $past(wdata_i[3:0]))
    else $error("loop bandwidth select not written");
  a_bw_refuse_wide: assert property (
    bw_wr && wdata_i[31:4] != 28'h0 |=> $stable(loop_bw_select_o))
    else $error("oversized bandwidth value taken");
  a_bw_holds_value: assert property (
    !bw_wr |=> $stable(loop_bw_select_o))
    else $error("bandwidth select changed without write");
  a_out0_spacing: assert property (
    out_pulse_o[0] |=> (!out_pulse_o[0])[*3])
    else $error("output 0 ratio below four");
  a_out1_spacing: assert property (
    out_pulse_o[1] |=> (!out_pulse_o[1])[*3])
    else $error("output 1 ratio below four");
  a_fb_spacing: assert property (
    feedback_pulse_o |=> (!feedback_pulse_o)[*7])
    else $error("feedback ratio below eight");
  a_read_idle_zero: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside read");
  a_unmapped_zero: assert property (
    rd_i && addr_i > 8'h24 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule : pll_divider_config_checker

// [verification/testbench.sv]
// self-checking bench for the divider configuration block
`timescale 1ns/1ps
module testbench;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic [7:0]  addr_i     = 8'h00;
  logic [31:0] wdata_i    = 32'h0;
  logic        wr_i       = 1'b0;
  logic        rd_i       = 1'b0;
  logic        osc_tick_i = 1'b1;
  logic        osc_half   = 1'b0;
  logic        clk_in0_i  = 1'b0;
  logic        clk_in1_i  = 1'b0;
  logic        wide       = 1'b0;
  logic        low_bw     = 1'b0;
  logic [2:0]  pin_cnt    = 3'h0;
  logic [31:0] rdata_o;
  logic [1:0]  clk_out_o;
  logic [1:0]  out_pulse_o;
  logic        feedback_pulse_o;
  logic        pd_ref_pulse_o;
  logic [3:0]  loop_bw_select_o;
  logic        low_bw_scale_o;
  logic        lock_ind_avail_o;
  logic [31:0] shd [0:9];
  int          fails;
  int          comparisons;
  int          f;
  int          s;
  wire  [3:0]  pls = {pd_ref_pulse_o, feedback_pulse_o, out_pulse_o};

  pll_divider_config pll_divider_config_i (
    .core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .osc_tick_i, .clk_in0_i, .clk_in1_i,
    .strap_wideband_i(wide),
    .strap_low_bw_i(low_bw),
    .clk_out_o, .out_pulse_o, .feedback_pulse_o, .pd_ref_pulse_o,
    .loop_bw_select_o, .low_bw_scale_o, .lock_ind_avail_o
  );

  always #5 core_clk_i = ~core_clk_i;

  // input pins run at a quarter and an eighth of the core rate;
  // the oscillator enable can drop to every other cycle
  always @(posedge core_clk_i) begin
    pin_cnt    <= pin_cnt + 3'h1;
    clk_in0_i  <= pin_cnt[1];
    clk_in1_i  <= pin_cnt[2];
    osc_tick_i <= osc_half ? !osc_tick_i : 1'b1;
  end

  task automatic end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1;
    chk($sformatf("reg_%h", a), e, rdata_o);
  endtask : rchk

  // write, read back, then check and clear the sticky reject flag
  task automatic try(input logic [7:0] a, input logic [31:0] v,
                     input logic ok);
    wr(a, v);
    if (ok)
      shd[a[5:2]] = v;
    rchk(a, shd[a[5:2]]);
    rchk(8'h24, {28'h0, !wide, low_bw, wide, !ok});
    wr(8'h24, 32'h1);
  endtask : try

  // period between two pulses; for outputs also the high cycles of the level
  task automatic per(input int k, input int e, input int eh = 0);
    int n;
    int h;
    repeat (2) begin
      n = 0;
      h = 0;
      do begin
        @(posedge core_clk_i);
        #1;
        n++;
        if (k < 2 && clk_out_o[k] === 1'b1)
          h++;
      end while (pls[k] !== 1'b1 && n < 5000);
    end
    chk($sformatf("period_%0d", k), 32'(e), 32'(n));
    if (k < 2)
      chk($sformatf("duty_%0d", k), 32'(eh), 32'(h));
  endtask : per

  task automatic do_reset(input logic w, input logic l);
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    wide    <= w;
    low_bw  <= l;
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1;
    shd = '{32'h4, 32'h1, 32'h1, 32'h4, 32'h20, 32'h1, 32'h1, 32'h0,
            32'h0, 32'h0};
  endtask : do_reset

  initial begin
    repeat (60000) @(posedge core_clk_i);
    fails++;
    end_of_test;
  end

  initial begin
    void'($urandom(94817));
    do_reset(1'b0, 1'b0);
    for (int i = 0; i < 9; i++)
      rchk(8'(i * 4), shd[i]);
    chk("lock_avail", 32'h1, {31'h0, lock_ind_avail_o});
    try(8'h00, 32'h3, 1'b0);
    try(8'h00, 32'hC, 1'b0);
    try(8'h00, 32'h1000B, 1'b0);
    try(8'h00, 32'hB, 1'b1);
    try(8'h04, 32'h3, 1'b0);
    try(8'h04, 32'h0, 1'b0);
    try(8'h04, 32'h100000, 1'b1);
    try(8'h04, 32'h100002, 1'b0);
    try(8'h0C, 32'h3, 1'b0);
    try(8'h10, 32'h1, 1'b0);
    try(8'h10, 32'h100000, 1'b1);
    try(8'h10, 32'h100002, 1'b0);
    try(8'h10, 32'h2, 1'b1);
    try(8'h14, 32'h0, 1'b0);
    try(8'h14, 32'h80000, 1'b1);
    try(8'h14, 32'h80001, 1'b0);
    try(8'h1C, 32'h10, 1'b0);
    try(8'h1C, 32'hF, 1'b1);
    chk("bw_out", 32'hF, {28'h0, loop_bw_select_o});
    repeat (4) begin
      f = 4 + $urandom % 8;
      s = 2 * (1 + $urandom % 4);
      try(8'h00, 32'(f), 1'b1);
      try(8'h04, 32'(s), 1'b1);
      try(8'h08, 32'h1, 1'b1);
      per(0, f * s, f * s / 2);
      per(1, f, 1);
      s = 2 * (1 + $urandom % 3);
      try(8'h0C, 32'(f), 1'b1);
      try(8'h10, 32'(s), 1'b1);
      per(2, f * s);
    end
    // ratio 22 split with the largest fast value, oscillator at half rate
    try(8'h00, 32'hB, 1'b1);
    try(8'h04, 32'h2, 1'b1);
    osc_half <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    per(0, 44, 22);
    per(1, 22, 1);
    osc_half <= 1'b0;
    try(8'h20, 32'h0, 1'b1);
    try(8'h14, 32'h3, 1'b1);
    per(3, 12);
    try(8'h18, 32'h2, 1'b1);
    try(8'h20, 32'h1, 1'b1);
    per(3, 16);
    wr(8'h30, 32'h5);
    rchk(8'h30, 32'h0);
    rchk(8'h24, 32'h8);
    // second reset mid-run selects the wideband, low-bandwidth variant
    do_reset(1'b1, 1'b1);
    chk("lock_avail", 32'h0, {31'h0, lock_ind_avail_o});
    chk("low_bw", 32'h1, {31'h0, low_bw_scale_o});
    try(8'h10, 32'h1E, 1'b0);
    try(8'h10, 32'h202, 1'b0);
    try(8'h10, 32'h21, 1'b0);
    try(8'h10, 32'h200, 1'b1);
    per(2, 4 * 512);
    end_of_test;
  end
endmodule : testbench

bind pll_divider_config pll_divider_config_checker checker_i (
  .core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .out_pulse_o, .feedback_pulse_o, .loop_bw_select_o
);
